/* File: rtl/uss_pkg.sv */
// Package for the synchronous slave serial port: register map, fields,
// reset values and shared types.
// Assumes a 32-bit APB slave, one register per aligned word.
package uss_pkg;

   // ==========================================================
   // Register indices as printed; byte address is index times four
   localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
   localparam logic [7:0] IDX_RX_STATUS   = 8'h18;
   localparam logic [7:0] IDX_TX_HOLD     = 8'h19;
   localparam logic [7:0] IDX_RX_DATA     = 8'h1A;
   localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_TX_STATUS   = 8'h98;
   localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;
   localparam logic [7:0] IDX_SLEEP_CTRL  = 8'hA0;

   // ==========================================================
   // Field positions
   localparam int FLD_RX_FULL   = 5;  // In irq flags / enables
   localparam int FLD_TX_EMPTY  = 4;
   localparam int FLD_PORT_EN   = 7;  // In receive status/control
   localparam int FLD_RX_NINE   = 6;
   localparam int FLD_SINGLE_RX = 5;
   localparam int FLD_CONT_RX   = 4;
   localparam int FLD_FRAMING   = 2;
   localparam int FLD_OVERRUN   = 1;
   localparam int FLD_RX_BIT8   = 0;
   localparam int FLD_CLK_SRC   = 7;  // In transmit status/control
   localparam int FLD_TX_NINE   = 6;
   localparam int FLD_TX_EN     = 5;
   localparam int FLD_SYNC      = 4;
   localparam int FLD_SHIFT_MT  = 1;
   localparam int FLD_TX_BIT8   = 0;

   // ==========================================================
   // Reset values and masks
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_TX_STAT  = 8'h02;
   localparam logic [7:0] MSK_IRQ_EN   = 8'hF7;
   localparam logic [7:0] MSK_RX_WR    = 8'hF8;
   localparam logic [7:0] MSK_TX_WR    = 8'hF5;
   localparam logic [3:0] BITS_EIGHT   = 4'h8;
   localparam logic [3:0] BITS_NINE    = 4'h9;
   localparam logic [1:0] FIFO_DEPTH   = 2'h2;

   typedef enum logic {
      USS_TX_IDLE,
      USS_TX_SHIFT
   } uss_tx_state_e;

endpackage

/* File: rtl/uss_link_if.sv */
// Interface carrying synchronised link events from the pin front end
// to the serial core. Assumes a single system clock.
`timescale 1ns/10ps
`default_nettype none
interface uss_link_if;
   logic clk_rise;   // One-cycle pulse, shift clock rose
   logic clk_fall;   // One-cycle pulse, shift clock fell
   logic data_in;    // Synchronised data line level
   modport front (output clk_rise, output clk_fall, output data_in);
   modport core  (input  clk_rise, input  clk_fall, input  data_in);
endinterface
`default_nettype wire

/* File: rtl/uss_pin_sync.sv */
// Pin front end: two-flop synchronisers for the external shift clock
// and data line, and edge pulses from the synchronised clock.
// Assumes shift clock far slower than the system clock.
`timescale 1ns/10ps
`default_nettype none
module uss_pin_sync (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic shift_clk_i,
   input  wire logic data_i,
   uss_link_if.front link
);
   import uss_pkg::*;

   typedef struct packed {
      logic [1:0] clk_sync;
      logic [1:0] dat_sync;
      logic       clk_prev;
   } uss_sync_s;

   uss_sync_s st;
   uss_sync_s next_st;

   // ==========================================================
   // Synchronisers; stage zero is only read by stage one
   always_comb begin
      next_st          = st;
      next_st.clk_sync = {st.clk_sync[0], shift_clk_i};
      next_st.dat_sync = {st.dat_sync[0], data_i};
      next_st.clk_prev = st.clk_sync[1];
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Each external edge yields exactly one pulse
   assign link.clk_rise = st.clk_sync[1] & ~st.clk_prev;
   assign link.clk_fall = ~st.clk_sync[1] & st.clk_prev;
   assign link.data_in  = st.dat_sync[1];

   AST_ONE_EDGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      link.clk_fall |=> !link.clk_fall)
      else $error("falling-edge pulse lasted more than one cycle");

endmodule
`default_nettype wire

/* File: rtl/uss_sync_slave.sv */
// Synchronous slave serial port: APB registers, transmit holding and
// shift registers, receive shift register, two-deep receive buffer.
// Assumes an external master drives the shift clock pin.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
module uss_sync_slave (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        shift_clk_i,
   input  wire logic        data_i,
   output logic             data_o,
   output logic             data_oe_o,
   output logic             wake_o
);
   import uss_pkg::*;

   uss_link_if link ();

   uss_pin_sync u_pin (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .shift_clk_i (shift_clk_i),
      .data_i      (data_i),
      .link        (link)
   );

   typedef struct packed {
      logic [31:0]   rdata;
      logic          ready;
      logic          slverr;
      logic          dout;
      logic          doe;
      logic          wake;
      logic [7:0]    irq_en;
      logic          port_en;
      logic          rx_nine;
      logic          single_rx;
      logic          cont_rx;
      logic          overrun;
      logic          framing;
      logic          clk_src;
      logic          tx_nine;
      logic          tx_en;
      logic          sync;
      logic          tx_bit8;
      logic [7:0]    baud;
      logic          sleep;
      logic [7:0]    hold;
      logic          hold_full;
      logic          hold_bit8;
      logic [8:0]    transmit_shift_register;
      logic [3:0]    tx_cnt;
      uss_tx_state_e tx_st;
      logic [8:0]    receive_shift_register;
      logic [3:0]    rx_cnt;
      logic [8:0]    fifo0;
      logic [8:0]    fifo1;
      logic [1:0]    fifo_cnt;
   } uss_state_s;

   uss_state_s st;
   uss_state_s next_st;

   logic       slave_mode;
   logic       rx_active;
   logic       tx_active;
   logic       access;
   logic [7:0] idx;
   logic       tx_empty_flag;
   logic       rx_full_flag;

   // ==========================================================
   // Mode decode: slave when port enabled, sync on and clock source clear
   assign slave_mode = st.sync & st.port_en & ~st.clk_src;
   assign rx_active  = slave_mode & st.cont_rx;
   assign tx_active  = slave_mode & st.tx_en & ~rx_active;
   assign access     = psel_i & penable_i & ~st.ready;
   assign idx        = paddr_i[9:2];
   assign tx_empty_flag = ~st.hold_full;
   assign rx_full_flag  = (st.fifo_cnt != 2'h0);

   // ==========================================================
   // Next-state logic: bus, transmitter, receiver
   always_comb begin
      next_st        = st;
      next_st.ready  = access;
      next_st.slverr = 1'b0;
      next_st.rdata  = '0;

      // Transmitter: load shift register when it is idle and a word is held
      if (!tx_active) begin
         next_st.tx_st = USS_TX_IDLE;
         next_st.doe   = 1'b0;
      end else begin
         case (st.tx_st)
            USS_TX_IDLE: begin
               if (st.hold_full) begin
                  next_st.transmit_shift_register       = {st.hold_bit8, st.hold};
                  next_st.hold_full = 1'b0;
                  next_st.tx_cnt    = st.tx_nine ? BITS_NINE : BITS_EIGHT;
                  next_st.tx_st     = USS_TX_SHIFT;
                  next_st.dout      = st.hold[0];
                  next_st.doe       = 1'b1;
               end
            end
            USS_TX_SHIFT: begin
               // Bit changes on rising edge, stands through the falling one
               if (link.clk_rise && st.tx_cnt != 4'h0) begin
                  next_st.tx_cnt = st.tx_cnt - 4'h1;
                  next_st.transmit_shift_register    = {1'b0, st.transmit_shift_register[8:1]};
                  next_st.dout   = st.transmit_shift_register[0];
               end
               // Pin is released only after the last bit has been sampled
               if (link.clk_fall && st.tx_cnt == 4'h0) begin
                  next_st.tx_st = USS_TX_IDLE;
                  next_st.doe   = 1'b0;
               end
            end
            default: next_st.tx_st = USS_TX_IDLE;
         endcase
      end

      // Receiver: sample on falling edge, keeps running while asleep
      if (!rx_active) begin
         next_st.rx_cnt = '0;
      end else if (link.clk_fall) begin
         next_st.receive_shift_register    = {link.data_in, st.receive_shift_register[8:1]};
         next_st.rx_cnt = st.rx_cnt + 4'h1;
         if (st.rx_cnt == (st.rx_nine ? BITS_NINE : BITS_EIGHT) - 4'h1) begin
            next_st.rx_cnt = '0;
            if (st.overrun) begin
               // Word dropped: transfers blocked until cleared
            end else if (st.fifo_cnt == FIFO_DEPTH) begin
               next_st.overrun = 1'b1;
            end else begin
               // Right-justify eight-bit words
               if (st.fifo_cnt == 2'h0) begin
                  next_st.fifo0 = st.rx_nine ? {link.data_in, st.receive_shift_register[8:1]}
                                   : {1'b0, link.data_in, st.receive_shift_register[8:2]};
               end else begin
                  next_st.fifo1 = st.rx_nine ? {link.data_in, st.receive_shift_register[8:1]}
                                   : {1'b0, link.data_in, st.receive_shift_register[8:2]};
               end
               next_st.fifo_cnt = st.fifo_cnt + 2'h1;
            end
         end
      end

      // Register access; takes effect in the access cycle
      if (access && pwrite_i) begin
         case (idx)
            IDX_IRQ_ENABLES: next_st.irq_en = pwdata_i[7:0] & MSK_IRQ_EN;
            IDX_RX_STATUS: begin
               next_st.port_en   = pwdata_i[FLD_PORT_EN];
               next_st.rx_nine   = pwdata_i[FLD_RX_NINE];
               next_st.single_rx = pwdata_i[FLD_SINGLE_RX];
               next_st.cont_rx   = pwdata_i[FLD_CONT_RX];
               if (!pwdata_i[FLD_CONT_RX]) begin
                  // An overrun raised in this very cycle still wins
                  next_st.overrun = next_st.overrun & ~st.overrun;
                  next_st.framing = 1'b0;
               end
            end
            IDX_TX_STATUS: begin
               next_st.clk_src = pwdata_i[FLD_CLK_SRC];
               next_st.tx_nine = pwdata_i[FLD_TX_NINE];
               next_st.tx_en   = pwdata_i[FLD_TX_EN];
               next_st.sync    = pwdata_i[FLD_SYNC];
               next_st.tx_bit8 = pwdata_i[FLD_TX_BIT8];
               if (!pwdata_i[FLD_TX_EN]) begin
                  next_st.hold_full = 1'b0;   // Transmitter reset
               end
            end
            IDX_TX_HOLD: begin
               // Latches current ninth bit with the data
               if (st.tx_en) begin
                  next_st.hold      = pwdata_i[7:0];
                  next_st.hold_bit8 = st.tx_bit8;
                  next_st.hold_full = 1'b1;
               end
            end
            IDX_BAUD_DIV:   next_st.baud  = pwdata_i[7:0];
            IDX_SLEEP_CTRL: next_st.sleep = pwdata_i[0];
            IDX_IRQ_FLAGS, IDX_RX_DATA: ;
            default: next_st.slverr = 1'b1;
         endcase
      end else if (access) begin
         case (idx)
            IDX_IRQ_FLAGS: begin
               next_st.rdata[FLD_RX_FULL]  = rx_full_flag;
               next_st.rdata[FLD_TX_EMPTY] = tx_empty_flag;
            end
            IDX_RX_STATUS: begin
               next_st.rdata[FLD_PORT_EN]   = st.port_en;
               next_st.rdata[FLD_RX_NINE]   = st.rx_nine;
               next_st.rdata[FLD_SINGLE_RX] = st.single_rx;
               next_st.rdata[FLD_CONT_RX]   = st.cont_rx;
               next_st.rdata[FLD_FRAMING]   = st.framing;
               next_st.rdata[FLD_OVERRUN]   = st.overrun;
               next_st.rdata[FLD_RX_BIT8]   = st.fifo0[8];
            end
            IDX_RX_DATA: begin
               // Read pops buffer, which advances the ninth bit
               next_st.rdata[7:0] = st.fifo0[7:0];
               if (st.fifo_cnt != 2'h0 && !next_st.fifo_cnt[1]) begin
                  next_st.fifo0    = next_st.fifo1;
               end
               if (st.fifo_cnt != 2'h0) begin
                  next_st.fifo0    = (next_st.fifo_cnt == 2'h2)
                                   ? next_st.fifo1 : st.fifo1;
                  next_st.fifo_cnt = next_st.fifo_cnt - 2'h1;
               end
            end
            IDX_IRQ_ENABLES: next_st.rdata[7:0] = st.irq_en;
            IDX_TX_STATUS: begin
               next_st.rdata[FLD_CLK_SRC]  = st.clk_src;
               next_st.rdata[FLD_TX_NINE]  = st.tx_nine;
               next_st.rdata[FLD_TX_EN]    = st.tx_en;
               next_st.rdata[FLD_SYNC]     = st.sync;
               next_st.rdata[FLD_SHIFT_MT] = (st.tx_st == USS_TX_IDLE);
               next_st.rdata[FLD_TX_BIT8]  = st.tx_bit8;
            end
            IDX_BAUD_DIV:   next_st.rdata[7:0] = st.baud;
            IDX_SLEEP_CTRL: next_st.rdata[0]   = st.sleep;
            IDX_TX_HOLD: ;
            default: next_st.slverr = 1'b1;
         endcase
      end

      // Wake request from enabled flags, independent of sleep state
      next_st.wake = (tx_empty_flag & st.irq_en[FLD_TX_EMPTY])
                   | (rx_full_flag & st.irq_en[FLD_RX_FULL]);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st         <= '0;
         st.tx_st   <= USS_TX_IDLE;
         st.irq_en  <= RST_ZERO;
         st.baud    <= RST_ZERO;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops
   assign prdata_o  = st.rdata;
   assign pready_o  = st.ready;
   assign pslverr_o = st.slverr;
   assign data_o    = st.dout;
   assign data_oe_o = st.doe;
   assign wake_o    = st.wake;

   // ==========================================================
   // Checks
   sequence s_second_queued;
      st.tx_st == USS_TX_SHIFT && st.hold_full;
   endsequence

   AST_TX_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (tx_active && st.tx_st == USS_TX_IDLE && st.hold_full && !access)
      |=> st.tx_st == USS_TX_SHIFT && !st.hold_full)
      else $error("holding word not moved to shift register");
   AST_TX_HOLD_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_second_queued |-> !tx_empty_flag)
      else $error("empty flag set with word still held");
   AST_TX_RELOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (s_second_queued ##1 (tx_active && st.tx_st == USS_TX_IDLE && !access))
      |=> st.tx_st == USS_TX_SHIFT ##0 tx_empty_flag)
      else $error("second word not reloaded");
   AST_TX_WAKE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (tx_empty_flag && st.irq_en[FLD_TX_EMPTY]) |=> wake_o)
      else $error("transmit wake missing");
   AST_RX_SINGLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!st.cont_rx && st.single_rx) |-> !rx_active)
      else $error("single receive enabled reception");
   AST_RX_FULL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($rose(rx_full_flag) && st.irq_en[FLD_RX_FULL]) |-> wake_o ##1 wake_o
      or ##1 wake_o)
      else $error("receive wake missing");
   AST_ERR_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($fell(st.cont_rx) && !$rose(st.overrun))
      |-> !st.overrun && !st.framing)
      else $error("errors not cleared with receive enable");
   AST_OVERRUN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(st.overrun) |-> $past(st.fifo_cnt) == FIFO_DEPTH)
      else $error("overrun without full buffer");
   AST_SLAVE_ONLY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      data_oe_o |-> $past(slave_mode))
      else $error("driving data outside slave mode");

endmodule
`default_nettype wire

/* File: testbench/uss_ext_master.sv */
// External synchronous master for the slave serial port: makes the
// shift clock per word and drives the data pin when it sends.
// Assumes the bench calls xfer and the device data pin is shared.
`timescale 1ns/10ps
`default_nettype none
module uss_ext_master (
   input  wire logic sys_clk_i,
   input  wire logic dev_data_i,
   input  wire logic dev_oe_i,
   output logic      shift_clk_o,
   output logic      data_o
);
   logic drv_en;
   logic drv_val;
   logic idle_pat = 1'b0;

   // =========================================================
   // Pin level
   // A released line toggles every cycle so a stale level never passes
   always_ff @(posedge sys_clk_i) begin
      idle_pat <= ~idle_pat;
   end

   // Whoever enables the pin owns it; nobody means a moving pattern
   always_comb begin
      if (drv_en)
         data_o = drv_val;
      else if (dev_oe_i)
         data_o = dev_data_i;
      else
         data_o = idle_pat;
   end

   initial begin
      shift_clk_o = 1'b0;
      drv_en      = 1'b0;
      drv_val     = 1'b0;
   end

   // =========================================================
   // One word, LSB first, 200 ns cells; clock rests low between words
   task automatic xfer(input int nbits, input logic send,
                       input logic [8:0] wval, output logic [8:0] rval);
      rval = 9'h000;
      #7;
      for (int i = 0; i < nbits; i++) begin
         drv_en  = send;
         drv_val = wval[i];
         #50;
         shift_clk_o = 1'b1;
         #100;
         shift_clk_o = 1'b0;
         rval[i] = data_o;
         #50;
      end
      drv_en = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_usart_sync_slave_mode.sv */
// Self-checking bench for the synchronous slave serial port.
// Assumes the APB slave and the external master model beside it.
`timescale 1ns/10ps
`default_nettype none
module tb_usart_sync_slave_mode;
   import uss_pkg::*;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sck;
   logic        din;
   logic        dout;
   logic        doe;
   logic        wake;
   logic [8:0]  w;
   logic [31:0] rd;
   logic        err;
   int          num_errors = 0;
   int          n_compared = 0;

   uss_sync_slave dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .shift_clk_i(sck), .data_i(din),
      .data_o(dout), .data_oe_o(doe), .wake_o(wake));
   uss_ext_master ext (.sys_clk_i(clk), .dev_data_i(dout),
      .dev_oe_i(doe), .shift_clk_o(sck), .data_o(din));

   // =========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready without assuming a latency
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {22'h0, idx, 2'h0};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      if (n >= 50)
         num_errors++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] msk,
                       input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd & {24'h000000, msk}, {24'h000000, exp});
   endtask

   // Bounded wait for the device to release the data pin
   task automatic wait_idle();
      int n;
      n = 0;
      while (doe !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200)
         num_errors++;
   endtask

   task automatic close_out();
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // =========================================================
   // Clock and watchdog; the whole run needs well under 100 us
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #300000;
      num_errors++;
      close_out();
   end

   // =========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rchk(IDX_TX_STATUS, 8'hFF, 8'h02);
      rchk(IDX_IRQ_ENABLES, 8'hFF, 8'h00);
      apb(1'b0, 8'h50, 8'h00);
      chk({31'h0, err}, 32'h1);
      // Slave transmit, two words queued back to back
      apb(1'b1, IDX_RX_STATUS, 8'h80);
      apb(1'b1, IDX_TX_STATUS, 8'h10);
      apb(1'b1, IDX_TX_STATUS, 8'h30);
      apb(1'b1, IDX_IRQ_ENABLES, 8'h10);
      apb(1'b1, IDX_TX_HOLD, 8'hA5);
      apb(1'b1, IDX_TX_HOLD, 8'h3C);
      rchk(IDX_IRQ_FLAGS, 8'h10, 8'h00);
      chk({31'h0, wake}, 32'h0);
      ext.xfer(8, 1'b0, 9'h000, w);
      chk({23'h0, w}, 32'hA5);
      rchk(IDX_IRQ_FLAGS, 8'h10, 8'h10);
      chk({31'h0, wake}, 32'h1);
      rchk(IDX_TX_STATUS, 8'h02, 8'h00);
      ext.xfer(8, 1'b0, 9'h000, w);
      chk({23'h0, w}, 32'h3C);
      wait_idle();
      rchk(IDX_TX_STATUS, 8'hFF, 8'h32);
      // Nine-bit transmit
      apb(1'b1, IDX_TX_STATUS, 8'h71);
      apb(1'b1, IDX_TX_HOLD, 8'h81);
      ext.xfer(9, 1'b0, 9'h000, w);
      chk({23'h0, w}, 32'h181);
      wait_idle();
      // Receive: single enable alone must not receive
      apb(1'b1, IDX_TX_STATUS, 8'h10);
      apb(1'b1, IDX_IRQ_ENABLES, 8'h20);
      apb(1'b1, IDX_RX_STATUS, 8'hA0);
      ext.xfer(8, 1'b1, 9'h077, w);
      rchk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
      apb(1'b1, IDX_RX_STATUS, 8'h90);
      ext.xfer(8, 1'b1, 9'h05A, w);
      rchk(IDX_IRQ_FLAGS, 8'h20, 8'h20);
      chk({31'h0, wake}, 32'h1);
      rchk(IDX_RX_DATA, 8'hFF, 8'h5A);
      rchk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
      // Three words into a two-deep buffer
      ext.xfer(8, 1'b1, 9'h011, w);
      ext.xfer(8, 1'b1, 9'h022, w);
      ext.xfer(8, 1'b1, 9'h033, w);
      rchk(IDX_RX_STATUS, 8'hFF, 8'h92);
      rchk(IDX_RX_DATA, 8'hFF, 8'h11);
      rchk(IDX_RX_DATA, 8'hFF, 8'h22);
      ext.xfer(8, 1'b1, 9'h044, w);
      rchk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
      apb(1'b1, IDX_RX_STATUS, 8'h80);
      rchk(IDX_RX_STATUS, 8'hFF, 8'h80);
      // Nine-bit receive, status read before data
      apb(1'b1, IDX_RX_STATUS, 8'hC0);
      apb(1'b1, IDX_RX_STATUS, 8'hD0);
      ext.xfer(9, 1'b1, 9'h1C3, w);
      rchk(IDX_RX_STATUS, 8'hFF, 8'hD1);
      rchk(IDX_RX_DATA, 8'hFF, 8'hC3);
      close_out();
   end
endmodule
`default_nettype wire
